/* File: fpd_consts.svh */
// timing, fault code and segment constants for the front panel display
`ifndef FPD_CONSTS_SVH
`define FPD_CONSTS_SVH

`define CLK_MHZ      100
`define MS_CYC       (`CLK_MHZ * 1000)
`define TEST_S       15
`define TEST_PASSES  2
`define TEST_RING    7
`define TEST_STEPS   11
`define TEST_STEP_MS ((`TEST_S * 1000) / (`TEST_PASSES * `TEST_STEPS))
`define FWD_S        1
`define FWD_MS       (`FWD_S * 1000)
`define BACK_MS      500
`define BACK_MIN_MS  (`BACK_MS / 2)
`define IDLE_MIN     5
`define IDLE_MS      (`IDLE_MIN * 60 * 1000)
`define PAUSE_MS     1500
`define BLINK_MS     250
`define MAIN_LAST    4'h8
`define SUB_LAST     4'h4
`define RED_FAULT    4'h1
`define SEG_CENTRE   6
`define SEG_DP       7

`define FC_CTRL      12'h004
`define FC_PROG_MEM  12'h030
`define FC_HALF_CYC  12'h041
`define FC_RAM       12'h050
`define FC_PAR_BLK1  12'h051
`define FC_PAR_BLK2  12'h052
`define FC_PAR_BOTH  12'h053
`define FC_PAR_KEY   12'h056
`define FC_REF_LOW   12'h195
`define FC_REF_HIGH  12'h203

`endif

/* File: fpd_pkg.sv */
// types shared by the front panel display blocks
package fpd_pkg;

   typedef struct packed {
      logic ctrl;
      logic prog_mem;
      logic half_cycle;
      logic ram;
      logic par_blk1;
      logic par_blk2;
      logic par_key;
      logic ref_low;
      logic ref_high;
   } fault_flags_t;

   typedef struct packed {
      logic [7:0] red;
      logic [7:0] g2;
      logic [7:0] g1;
      logic [7:0] g0;
   } panel_t;

   typedef struct packed {
      logic press;
      logic fwd;
      logic back;
      logic rel;
   } btn_ev_t;

   typedef enum logic [5:0] {
      MODE_TEST  = 6'h01,
      MODE_DARK  = 6'h02,
      MODE_MAIN  = 6'h04,
      MODE_SUB   = 6'h08,
      MODE_SET   = 6'h10,
      MODE_FAULT = 6'h20
   } mode_t;

   typedef enum logic [1:0] {
      TST_RUN  = 2'h1,
      TST_DONE = 2'h2
   } tst_t;

   typedef struct packed {
      logic        prev;
      logic        fired;
      logic [10:0] ms;
      btn_ev_t     ev;
   } bt_st_t;

   typedef struct packed {
      tst_t       st;
      logic       pass;
      logic [3:0] step;
      logic [9:0] ms;
      panel_t     seg;
   } tst_st_t;

   typedef struct packed {
      mode_t       mode;
      logic [3:0]  menu;
      logic [3:0]  sub;
      logic [16:0] div;
      logic        tick;
      logic [18:0] idle;
      logic [10:0] pause;
      logic        pause_on;
      logic [7:0]  blink_ms;
      logic        blink;
      logic        op_ind;
      logic [3:0]  op_code;
      logic [1:0]  prog_cnt;
      logic        led_keep;
      logic        fault;
      logic [11:0] fcode;
      logic        relay;
      logic        ind_rst;
      logic        set_enter;
      logic        set_store;
      logic        led;
      panel_t      panel;
   } menu_st_t;

endpackage : fpd_pkg

/* File: button_timer.sv */
// push button press timer giving press, forward, backward and release events
`timescale 1ns/1ps
`include "fpd_consts.svh"

module button_timer #(
   parameter bit REPEAT = 1'b1
) (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       ms_tick,
   input  wire logic       btn,
   output fpd_pkg::btn_ev_t ev
);

   fpd_pkg::bt_st_t s_r;
   fpd_pkg::bt_st_t s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.ev = '0;
      s_nxt.prev = btn;
      if (btn && !s_r.prev)
      begin
         s_nxt.ev.press = 1'b1;
         s_nxt.ms = '0;
         s_nxt.fired = 1'b0;
      end
      else if (btn && ms_tick && s_r.ms != 11'(`FWD_MS))
      begin
         s_nxt.ms = s_r.ms + 11'h001;
         if (s_nxt.ms == 11'(`FWD_MS))
         begin
            s_nxt.ev.fwd = 1'b1;
            s_nxt.fired = 1'b1;
            if (REPEAT)
               s_nxt.ms = '0;
         end
      end
      else if (!btn && s_r.prev)
      begin
         s_nxt.ev.rel = 1'b1;
         if (!s_r.fired && s_r.ms >= 11'(`BACK_MIN_MS))
            s_nxt.ev.back = 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign ev = s_r.ev;

endmodule : button_timer

/* File: segment_test.sv */
// power-on segment walk over all four digits
`timescale 1ns/1ps
`include "fpd_consts.svh"

module segment_test (
   input  wire logic      clk_sys,
   input  wire logic      rst,
   input  wire logic      ms_tick,
   input  wire logic      abort,
   output fpd_pkg::panel_t seg,
   output logic           busy
);

   fpd_pkg::tst_st_t s_r;
   fpd_pkg::tst_st_t s_nxt;

   // clockwise ring: a, b, c, dp, d, e, f
   function automatic int ring_idx(input logic [3:0] st);
      case (st)
         4'h0:    ring_idx = 0;
         4'h1:    ring_idx = 1;
         4'h2:    ring_idx = 2;
         4'h3:    ring_idx = `SEG_DP;
         4'h4:    ring_idx = 3;
         4'h5:    ring_idx = 4;
         default: ring_idx = 5;
      endcase
   endfunction : ring_idx

   always_comb
   begin
      logic [31:0] v;
      v = '0;
      s_nxt = s_r;
      if (s_r.st == fpd_pkg::TST_RUN)
      begin
         if (abort)
            s_nxt.st = fpd_pkg::TST_DONE;
         else if (ms_tick)
         begin
            if (s_r.ms == 10'(`TEST_STEP_MS - 1))
            begin
               s_nxt.ms = '0;
               if (s_r.step == 4'(`TEST_STEPS - 1))
               begin
                  s_nxt.step = '0;
                  if (s_r.pass)
                     s_nxt.st = fpd_pkg::TST_DONE;
                  s_nxt.pass = 1'b1;
               end
               else
                  s_nxt.step = s_r.step + 4'h1;
            end
            else
               s_nxt.ms = s_r.ms + 10'h001;
         end
      end
      if (s_nxt.st == fpd_pkg::TST_RUN)
      begin
         for (int d = 0; d < 4; d++)
         begin
            if (s_nxt.step < 4'(`TEST_RING))
               v[d * 8 + ring_idx(s_nxt.step)] = 1'b1;
            else if (s_nxt.step == 4'(`TEST_RING + 3 - d))
               v[d * 8 + `SEG_CENTRE] = 1'b1;
         end
      end
      s_nxt.seg = v;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         s_r <= '0;
         s_r.st <= fpd_pkg::TST_RUN;
      end
      else
         s_r <= s_nxt;
   end

   assign seg = s_r.seg;
   assign busy = (s_r.st == fpd_pkg::TST_RUN);

endmodule : segment_test

/* File: front_panel_display_menu.sv */
// front panel display and push button menu controller
`timescale 1ns/1ps
`include "fpd_consts.svh"

module front_panel_display_menu #(
   parameter int MS_CYC_P  = `MS_CYC,
   parameter int IDLE_MS_P = `IDLE_MS
) (
   input  wire logic                clk_sys,
   input  wire logic                rst,
   input  wire logic                step_btn,
   input  wire logic                prog_btn,
   input  wire logic [11:0]         value_bcd,
   input  wire logic                value_has_led,
   input  wire logic                op_ind_set,
   input  wire logic [3:0]          op_ind_code,
   input  wire fpd_pkg::fault_flags_t fault_flags,
   output fpd_pkg::panel_t          panel,
   output logic                     value_led,
   output logic                     internal_fault_indicator,
   output logic                     supervision_relay,
   output logic                     indicator_reset,
   output logic                     setting_enter,
   output logic                     setting_store,
   output logic [3:0]               menu_pos,
   output logic [3:0]               sub_pos
);

   fpd_pkg::menu_st_t s_r;
   fpd_pkg::menu_st_t s_nxt;
   fpd_pkg::btn_ev_t  sev;
   fpd_pkg::btn_ev_t  pev;
   fpd_pkg::panel_t   test_seg;
   logic              test_busy;

   // ---------------------------------------------------------------
   // button timing and power-on test
   // ---------------------------------------------------------------
   button_timer #(.REPEAT(1'b1)) u_step (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ms_tick (s_r.tick),
      .btn     (step_btn),
      .ev      (sev)
   );

   button_timer #(.REPEAT(1'b1)) u_prog (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ms_tick (s_r.tick),
      .btn     (prog_btn),
      .ev      (pev)
   );

   segment_test u_test (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ms_tick (s_r.tick),
      .abort   (sev.press),
      .seg     (test_seg),
      .busy    (test_busy)
   );

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] seg7(input logic [3:0] d);
      case (d)
         4'h0:    seg7 = 8'h3f;
         4'h1:    seg7 = 8'h06;
         4'h2:    seg7 = 8'h5b;
         4'h3:    seg7 = 8'h4f;
         4'h4:    seg7 = 8'h66;
         4'h5:    seg7 = 8'h6d;
         4'h6:    seg7 = 8'h7d;
         4'h7:    seg7 = 8'h07;
         4'h8:    seg7 = 8'h7f;
         4'h9:    seg7 = 8'h6f;
         default: seg7 = 8'h00;
      endcase
   endfunction : seg7

   function automatic logic [11:0] fault_code(
      input fpd_pkg::fault_flags_t f);
      if (f.ctrl)
         fault_code = `FC_CTRL;
      else if (f.prog_mem)
         fault_code = `FC_PROG_MEM;
      else if (f.half_cycle)
         fault_code = `FC_HALF_CYC;
      else if (f.ram)
         fault_code = `FC_RAM;
      else if (f.par_blk1 && f.par_blk2)
         fault_code = `FC_PAR_BOTH;
      else if (f.par_blk1)
         fault_code = `FC_PAR_BLK1;
      else if (f.par_blk2)
         fault_code = `FC_PAR_BLK2;
      else if (f.par_key)
         fault_code = `FC_PAR_KEY;
      else if (f.ref_low)
         fault_code = `FC_REF_LOW;
      else
         fault_code = `FC_REF_HIGH;
   endfunction : fault_code

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      logic store_req;
      logic idle_out;
      store_req = (sev.press && prog_btn) || (pev.press && step_btn);
      idle_out = 1'b0;
      s_nxt = s_r;
      s_nxt.ind_rst = 1'b0;
      s_nxt.set_enter = 1'b0;
      s_nxt.set_store = 1'b0;

      // millisecond tick and blink rate
      s_nxt.tick = 1'b0;
      if (s_r.div == 17'(MS_CYC_P - 1))
      begin
         s_nxt.div = '0;
         s_nxt.tick = 1'b1;
      end
      else
         s_nxt.div = s_r.div + 17'h0_0001;
      if (s_r.tick)
      begin
         if (s_r.blink_ms == 8'(`BLINK_MS - 1))
         begin
            s_nxt.blink_ms = '0;
            s_nxt.blink = !s_r.blink;
         end
         else
            s_nxt.blink_ms = s_r.blink_ms + 8'h01;
      end

      // latched operation indicator, set beats clear
      if (sev.press)
      begin
         s_nxt.ind_rst = 1'b1;
         s_nxt.op_ind = 1'b0;
      end
      if (op_ind_set)
      begin
         s_nxt.op_ind = 1'b1;
         s_nxt.op_code = op_ind_code;
      end

      // inactivity time-out
      if (sev.press)
         s_nxt.idle = '0;
      else if (s_r.tick && s_r.idle != 19'(IDLE_MS_P - 1))
      begin
         s_nxt.idle = s_r.idle + 19'h0_0001;
         idle_out = (s_nxt.idle == 19'(IDLE_MS_P - 1));
      end

      // pause at dark while step is held
      if (sev.rel)
         s_nxt.pause_on = 1'b0;
      else if (s_r.tick && s_r.pause_on)
      begin
         if (s_r.pause == 11'h000)
            s_nxt.pause_on = 1'b0;
         else
            s_nxt.pause = s_r.pause - 11'h001;
      end

      if (pev.press)
         s_nxt.prog_cnt = '0;
      else if (pev.fwd && s_r.prog_cnt != 2'h3)
         s_nxt.prog_cnt = s_r.prog_cnt + 2'h1;

      case (s_r.mode)
         fpd_pkg::MODE_TEST:
         begin
            if (sev.press || !test_busy)
               s_nxt.mode = fpd_pkg::MODE_DARK;
         end
         fpd_pkg::MODE_DARK:
         begin
            if (sev.fwd && !s_r.pause_on)
            begin
               s_nxt.mode = fpd_pkg::MODE_MAIN;
               s_nxt.menu = 4'h1;
            end
         end
         fpd_pkg::MODE_MAIN:
         begin
            if (idle_out)
            begin
               s_nxt.mode = fpd_pkg::MODE_DARK;
               s_nxt.menu = '0;
            end
            else if (pev.fwd && s_r.prog_cnt == 2'h1)
            begin
               s_nxt.mode = fpd_pkg::MODE_SET;
               s_nxt.set_enter = 1'b1;
               s_nxt.led_keep = value_has_led;
            end
            else if (pev.rel && s_r.prog_cnt == 2'h1)
            begin
               s_nxt.mode = fpd_pkg::MODE_SUB;
               s_nxt.sub = 4'h1;
               s_nxt.led_keep = value_has_led;
            end
            else if (sev.fwd)
            begin
               if (s_r.menu == `MAIN_LAST)
               begin
                  s_nxt.mode = fpd_pkg::MODE_DARK;
                  s_nxt.menu = '0;
                  s_nxt.pause_on = 1'b1;
                  s_nxt.pause = 11'(`PAUSE_MS);
               end
               else
                  s_nxt.menu = s_r.menu + 4'h1;
            end
            else if (sev.back)
            begin
               if (s_r.menu == 4'h1)
               begin
                  s_nxt.mode = fpd_pkg::MODE_DARK;
                  s_nxt.menu = '0;
               end
               else
                  s_nxt.menu = s_r.menu - 4'h1;
            end
         end
         fpd_pkg::MODE_SUB:
         begin
            if (idle_out)
            begin
               s_nxt.mode = fpd_pkg::MODE_DARK;
               s_nxt.menu = '0;
               s_nxt.sub = '0;
            end
            else if (pev.fwd && s_r.prog_cnt == 2'h0)
            begin
               s_nxt.mode = fpd_pkg::MODE_SET;
               s_nxt.set_enter = 1'b1;
            end
            else if ((sev.fwd && s_r.sub == `SUB_LAST) ||
                     (sev.back && s_r.sub == 4'h1))
            begin
               s_nxt.mode = fpd_pkg::MODE_MAIN;
               s_nxt.sub = '0;
            end
            else if (sev.fwd)
               s_nxt.sub = s_r.sub + 4'h1;
            else if (sev.back)
               s_nxt.sub = s_r.sub - 4'h1;
         end
         fpd_pkg::MODE_SET:
         begin
            if (store_req)
               s_nxt.set_store = 1'b1;
            if (store_req || (pev.fwd && s_r.prog_cnt != 2'h0))
               s_nxt.mode = (s_r.sub == 4'h0) ? fpd_pkg::MODE_MAIN
                                              : fpd_pkg::MODE_SUB;
         end
         fpd_pkg::MODE_FAULT:
            s_nxt.mode = fpd_pkg::MODE_FAULT;
         default:
            s_nxt.mode = fpd_pkg::MODE_DARK;
      endcase

      // permanent fault overrides every mode
      if (|fault_flags && !s_r.fault)
      begin
         s_nxt.fault = 1'b1;
         s_nxt.relay = 1'b0;
         s_nxt.fcode = fault_code(fault_flags);
      end
      if (s_nxt.fault)
         s_nxt.mode = fpd_pkg::MODE_FAULT;

      // display image
      s_nxt.panel = '0;
      s_nxt.led = 1'b0;
      case (s_nxt.mode)
         fpd_pkg::MODE_TEST:
            s_nxt.panel = test_seg;
         fpd_pkg::MODE_DARK:
         begin
            if (s_nxt.op_ind)
               s_nxt.panel.red = seg7(s_nxt.op_code);
         end
         fpd_pkg::MODE_MAIN:
         begin
            s_nxt.panel.red = seg7(s_nxt.menu);
            s_nxt.panel.g2 = seg7(value_bcd[11:8]);
            s_nxt.panel.g1 = seg7(value_bcd[7:4]);
            s_nxt.panel.g0 = seg7(value_bcd[3:0]);
            s_nxt.led = value_has_led;
         end
         fpd_pkg::MODE_SUB:
         begin
            s_nxt.panel.red = s_nxt.blink ? seg7(s_nxt.sub) : 8'h00;
            s_nxt.panel.g2 = seg7(value_bcd[11:8]);
            s_nxt.panel.g1 = seg7(value_bcd[7:4]);
            s_nxt.panel.g0 = seg7(value_bcd[3:0]);
            s_nxt.led = s_nxt.led_keep;
         end
         fpd_pkg::MODE_SET:
         begin
            if (s_nxt.blink)
            begin
               s_nxt.panel.red = seg7((s_nxt.sub == 4'h0) ? s_nxt.menu
                                                          : s_nxt.sub);
               s_nxt.panel.g2 = seg7(value_bcd[11:8]);
               s_nxt.panel.g1 = seg7(value_bcd[7:4]);
               s_nxt.panel.g0 = seg7(value_bcd[3:0]);
            end
            s_nxt.led = s_nxt.led_keep;
         end
         fpd_pkg::MODE_FAULT:
         begin
            s_nxt.panel.red = seg7(`RED_FAULT);
            s_nxt.panel.g2 = seg7(s_nxt.fcode[11:8]);
            s_nxt.panel.g1 = seg7(s_nxt.fcode[7:4]);
            s_nxt.panel.g0 = seg7(s_nxt.fcode[3:0]);
         end
         default:
            s_nxt.panel = '0;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         s_r <= '0;
         s_r.mode <= fpd_pkg::MODE_TEST;
         s_r.relay <= 1'b1;
      end
      else
         s_r <= s_nxt;
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign panel = s_r.panel;
   assign value_led = s_r.led;
   assign internal_fault_indicator = s_r.fault;
   assign supervision_relay = s_r.relay;
   assign indicator_reset = s_r.ind_rst;
   assign setting_enter = s_r.set_enter;
   assign setting_store = s_r.set_store;
   assign menu_pos = s_r.menu;
   assign sub_pos = s_r.sub;

endmodule : front_panel_display_menu

/* File: front_panel_display_menu_monitor.sv */
// concurrent checks on the front panel display ports
`timescale 1ns/1ps
module front_panel_display_menu_monitor (
   input wire logic                  clk_sys,
   input wire logic                  rst,
   input wire logic                  step_btn,
   input wire logic                  prog_btn,
   input wire logic [11:0]           value_bcd,
   input wire logic                  value_has_led,
   input wire logic                  op_ind_set,
   input wire logic [3:0]            op_ind_code,
   input wire fpd_pkg::fault_flags_t fault_flags,
   input wire fpd_pkg::panel_t       panel,
   input wire logic                  value_led,
   input wire logic                  internal_fault_indicator,
   input wire logic                  supervision_relay,
   input wire logic                  indicator_reset,
   input wire logic                  setting_enter,
   input wire logic                  setting_store,
   input wire logic [3:0]            menu_pos,
   input wire logic [3:0]            sub_pos
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   relay_drop_a:
   assert property (supervision_relay != internal_fault_indicator)
      else $error("relay and fault indicator disagree");
   fault_latch_a:
   assert property (fault_flags != '0 |-> ##[1:3] internal_fault_indicator)
      else $error("fault not latched");
   fault_hold_a:
   assert property (internal_fault_indicator |=> internal_fault_indicator)
      else $error("fault indication cleared");
   fault_red_a:
   assert property (internal_fault_indicator [*3] |-> panel.red == 8'h06)
      else $error("fault red digit not one");
   step_clear_a:
   assert property ($rose(step_btn) |-> ##2 indicator_reset)
      else $error("no indicator reset on step press");
   clear_pulse_a:
   assert property (indicator_reset |=> !indicator_reset)
      else $error("indicator reset longer than one cycle");
   dark_fwd_a:
   assert property (menu_pos == 4'h0 |=> menu_pos inside {4'h0, 4'h1})
      else $error("backward step from dark");
   prog_quick_a:
   assert property ($rose(prog_btn) |=> !setting_enter [*8])
      else $error("setting entered without hold");
endmodule : front_panel_display_menu_monitor

/* File: operator_model.sv */
// operator pressing the two front panel buttons
`timescale 1ns/1ps
module operator_model #(
   parameter int MS_CYC = 10
) (
   input  wire logic clk_sys,
   output logic      step_btn,
   output logic      prog_btn
);
   initial
   begin
      step_btn = 1'h0;
      prog_btn = 1'h0;
   end

   // hold one button for ms, then release and settle
   task automatic press(input bit prog, input int ms);
      @(posedge clk_sys);
      #1;
      if (prog)
         prog_btn = 1'h1;
      else
         step_btn = 1'h1;
      repeat (ms * MS_CYC) @(posedge clk_sys);
      #1;
      step_btn = 1'h0;
      prog_btn = 1'h0;
      repeat (20) @(posedge clk_sys);
      #1;
   endtask : press

   // program held, step added on top, both released together
   task automatic chord();
      @(posedge clk_sys);
      #1;
      prog_btn = 1'h1;
      repeat (20) @(posedge clk_sys);
      #1;
      step_btn = 1'h1;
      repeat (20) @(posedge clk_sys);
      #1;
      step_btn = 1'h0;
      prog_btn = 1'h0;
      repeat (20) @(posedge clk_sys);
      #1;
   endtask : chord
endmodule : operator_model

/* File: front_panel_display_menu_tb_top.sv */
// self-checking bench for the front panel display menu
`timescale 1ns/1ps
module front_panel_display_menu_tb_top;
   localparam int MS_CYC  = 5;
   localparam int IDLE_MS = 3000;
   logic                  clk_sys;
   logic                  rst;
   wire                   step_btn;
   wire                   prog_btn;
   logic [11:0]           value_bcd;
   logic                  value_has_led;
   logic                  op_ind_set;
   logic [3:0]            op_ind_code;
   fpd_pkg::fault_flags_t fault_flags;
   fpd_pkg::panel_t       panel;
   logic                  value_led;
   logic                  internal_fault_indicator;
   logic                  supervision_relay;
   logic                  indicator_reset;
   logic                  setting_enter;
   logic                  setting_store;
   logic [3:0]            menu_pos;
   logic [3:0]            sub_pos;
   int                    n_mismatch;
   int                    total_checks;
   int                    n_enter;
   int                    n_store;

   front_panel_display_menu #(.MS_CYC_P(MS_CYC), .IDLE_MS_P(IDLE_MS))
      i_front_panel_display_menu (.clk_sys, .rst, .step_btn, .prog_btn,
      .value_bcd, .value_has_led, .op_ind_set, .op_ind_code, .fault_flags,
      .panel, .value_led, .internal_fault_indicator, .supervision_relay,
      .indicator_reset, .setting_enter, .setting_store, .menu_pos,
      .sub_pos);
   operator_model #(.MS_CYC(MS_CYC)) i_operator_model (.clk_sys,
      .step_btn, .prog_btn);

   // ---------------------------------------------------------------
   // clock, shared helpers
   // ---------------------------------------------------------------
   initial
   begin
      clk_sys = 1'h0;
      forever #5 clk_sys = ~clk_sys;
   end

   // one-cycle setting pulses, counted where they stand
   always @(posedge clk_sys)
   begin
      if (setting_enter === 1'h1)
         n_enter <= n_enter + 1;
      if (setting_store === 1'h1)
         n_store <= n_store + 1;
   end

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : wait_cyc

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_test_abort();
      wait_cyc(4);
      chk("test_lit", 32'h0000_0001, {31'h0, panel != '0});
      chk("relay_in_test", 32'h0000_0001, {31'h0, supervision_relay});
      i_operator_model.press(1'b0, 100);
      chk("panel_after_abort", 32'h0000_0000, panel);
      $display("test abort done");
   endtask : t_test_abort

   task automatic t_dark_back();
      i_operator_model.press(1'b0, 500);
      chk("menu_dark_back", 32'h0000_0000, {28'h0, menu_pos});
      $display("test dark back done");
   endtask : t_dark_back

   task automatic t_fwd_back();
      i_operator_model.press(1'b0, 1100);
      chk("menu_fwd1", 32'h0000_0001, {28'h0, menu_pos});
      chk("red_lit", 32'h0000_0001, {31'h0, panel.red != '0});
      i_operator_model.press(1'b0, 1100);
      chk("menu_fwd2", 32'h0000_0002, {28'h0, menu_pos});
      i_operator_model.press(1'b0, 500);
      chk("menu_back", 32'h0000_0001, {28'h0, menu_pos});
      $display("test forward back done");
   endtask : t_fwd_back

   task automatic t_setting();
      i_operator_model.press(1'b1, 2100);
      chk("setting_enter", 32'h0000_0001, n_enter);
      i_operator_model.chord();
      chk("setting_store", 32'h0000_0001, n_store);
      chk("menu_after_store", 32'h0000_0001, {28'h0, menu_pos});
      $display("test setting done");
   endtask : t_setting

   task automatic t_sub_idle();
      i_operator_model.press(1'b1, 1100);
      chk("sub_entry", 32'h0000_0001, {28'h0, sub_pos});
      chk("led_in_sub", 32'h0000_0001, {31'h0, value_led});
      i_operator_model.press(1'b0, 1100);
      chk("sub_fwd", 32'h0000_0002, {28'h0, sub_pos});
      wait_cyc((IDLE_MS + 200) * MS_CYC);
      chk("idle_menu", 32'h0000_0000, {28'h0, menu_pos});
      chk("idle_sub", 32'h0000_0000, {28'h0, sub_pos});
      $display("test submenu idle done");
   endtask : t_sub_idle

   task automatic t_op_ind();
      op_ind_code = 4'h3;
      op_ind_set  = 1'h1;
      wait_cyc(1);
      op_ind_set  = 1'h0;
      wait_cyc(5);
      chk("op_red", 32'h0000_004F, {24'h0, panel.red});
      chk("op_green", 32'h0000_0000, {8'h0, panel.g2, panel.g1, panel.g0});
      i_operator_model.press(1'b0, 100);
      chk("op_cleared", 32'h0000_0000, panel);
      $display("test operation indication done");
   endtask : t_op_ind

   task automatic t_fault();
      fault_flags.ram = 1'h1;
      wait_cyc(5);
      chk("fault_ind", 32'h0000_0001, {31'h0, internal_fault_indicator});
      chk("fault_relay", 32'h0000_0000, {31'h0, supervision_relay});
      chk("fault_red", 32'h0000_0006, {24'h0, panel.red});
      chk("fault_code5", 32'h0000_006D, {24'h0, panel.g1});
      fault_flags = '0;
      i_operator_model.press(1'b0, 100);
      chk("fault_kept", 32'h0000_0006, {24'h0, panel.red});
      rst = 1'h1;
      wait_cyc(2);
      rst = 1'h0;
      wait_cyc(2);
      chk("fault_serviced", 32'h0000_0001, {31'h0, supervision_relay});
      $display("test fault done");
   endtask : t_fault

   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial
   begin
      n_mismatch    = 0;
      total_checks  = 0;
      rst           = 1'h1;
      value_bcd     = 12'h123;
      value_has_led = 1'h1;
      op_ind_set    = 1'h0;
      op_ind_code   = 4'h0;
      fault_flags   = '0;
      wait_cyc(2);
      rst = 1'h0;
      t_test_abort();
      t_dark_back();
      t_fwd_back();
      t_setting();
      t_sub_idle();
      t_op_ind();
      t_fault();
      complete_run();
   end

   initial
   begin
      #1_500_000;
      n_mismatch++;
      complete_run();
   end
endmodule : front_panel_display_menu_tb_top

bind front_panel_display_menu front_panel_display_menu_monitor i_mon (
   .clk_sys, .rst, .step_btn, .prog_btn, .value_bcd, .value_has_led,
   .op_ind_set, .op_ind_code, .fault_flags, .panel, .value_led,
   .internal_fault_indicator, .supervision_relay, .indicator_reset,
   .setting_enter, .setting_store, .menu_pos, .sub_pos);
